// [reset_params.svh]
`ifndef RESET_PARAMS_SVH
`define RESET_PARAMS_SVH

// Register byte addresses (word aligned)
`define ADDR_STATUS      8'h0c
`define ADDR_EVENTS      8'h10
`define ADDR_MASK        8'h14
`define ADDR_CONTROL     8'h18
`define ADDR_KEEP        8'h1c
// Printed index of the core status register
`define IDX_STATUS       8'h03

// Core status field positions
`define BIT_TIMEOUT      4
`define BIT_POWERDOWN    3
`define STATUS_POR_VALUE 8'h18
`define STATUS_PAGE_MASK 8'h1f

// Event bit positions
`define EV_POR           0
`define EV_PIN           1
`define EV_PIN_WAKE      2
`define EV_DOG           3
`define EV_DOG_WAKE      4
`define EV_RELEASE       5

// Control bits
`define CTL_SLEEP        0

// Timing
`define CLK_MHZ          40
`define STARTUP_US       18000
`define STARTUP_CYCLES   (`STARTUP_US * `CLK_MHZ)
`define CLKOUT_DIV       4

`endif

// [reset_pkg.sv]
package reset_pkg;

  typedef enum logic [1:0] {
    cause_none  = 2'b00,
    cause_reset = 2'b01,
    cause_wake  = 2'b10
  } wake_t;

  typedef enum logic [1:0] {
    st_hold  = 2'b00,
    st_count = 2'b01,
    st_run   = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// [reset_source_and_startup_timer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "reset_params.svh"

module reset_source_and_startup_timer
  import reset_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  supply_rise,
  input  wire logic                  master_clear_pin,
  input  wire logic                  watchdog_timeout,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire reset_pkg::wb_req_t    wb_req,
  output logic [31:0]                dat_o,
  output logic                       ack_o,
  output logic                       chip_reset,
  output logic                       instr_clock_out,
  output logic                       irq
);
  import reset_pkg::*;

  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STARTUP_CYCLES - 1);

  // Reset latch, timer and divider state
  logic          reset_latch;
  logic          next_reset_latch;
  logic [CW-1:0] device_startup_timer;
  logic [CW-1:0] next_device_startup_timer;
  logic [1:0]    clk_div;
  logic [1:0]    next_clk_div;
  logic          next_instr_clock_out;
  logic          por_seen;
  logic          next_por_seen;

  // Registers seen by software
  logic [7:0]    core_status_flags;
  logic [7:0]    next_core_status_flags;
  logic [7:0]    events;
  logic [7:0]    next_events;
  logic [7:0]    mask;
  logic [7:0]    next_mask;
  logic [7:0]    control;
  logic [7:0]    next_control;
  logic [7:0]    keep_reg;
  logic [7:0]    next_keep_reg;
  logic [31:0]   next_dat_o;
  logic          next_ack_o;
  logic          next_irq;

  // Cause decode
  logic          halted;
  logic          pin_low;
  logic          dog_event;
  logic          por_event;
  logic          any_cause;
  logic          timer_done;
  logic          wr;
  logic          rd;
  logic [7:0]    wdata;

  always_comb begin
    halted     = control[`CTL_SLEEP];
    pin_low    = !master_clear_pin;
    dog_event  = watchdog_timeout;
    // Only a rising supply triggers power-on reset
    por_event  = supply_rise;
    any_cause  = por_event | pin_low | dog_event;
    timer_done = (device_startup_timer == LAST);
    wr         = cyc_i && stb_i && !ack_o && wb_req.we;
    rd         = cyc_i && stb_i && !ack_o && !wb_req.we;
    wdata      = wb_req.sel[0] ? wb_req.dat[7:0] : 8'h00;
  end

  // Reset latch and start-up timer
  always_comb begin
    next_reset_latch          = reset_latch;
    next_device_startup_timer = device_startup_timer;
    next_por_seen             = por_seen;
    if (any_cause) begin
      next_reset_latch          = 1'b1;
      next_device_startup_timer = '0;
      if (por_event)
        next_por_seen = 1'b1;
    end else if (reset_latch) begin
      // Counts only with the pin high; timeout frees the chip
      if (timer_done) begin
        next_reset_latch          = 1'b0;
        next_device_startup_timer = '0;
      end else begin
        next_device_startup_timer = device_startup_timer + 1'b1;
      end
    end
  end

  // Divide-by-four clock output
  always_comb begin
    next_clk_div         = clk_div + 2'h1;
    next_instr_clock_out = next_clk_div[1];
  end

  // Core status: load per cause, flags per table
  always_comb begin
    next_core_status_flags = core_status_flags;
    if (por_event) begin
      next_core_status_flags = `STATUS_POR_VALUE;
    end else if (pin_low || dog_event) begin
      // Page bits cleared, arithmetic bits untouched
      next_core_status_flags = core_status_flags & `STATUS_PAGE_MASK;
      if (dog_event) begin
        next_core_status_flags[`BIT_TIMEOUT]   = 1'b0;
        next_core_status_flags[`BIT_POWERDOWN] = !halted;
      end else if (halted) begin
        next_core_status_flags[`BIT_TIMEOUT]   = 1'b1;
        next_core_status_flags[`BIT_POWERDOWN] = 1'b0;
      end
    end else if (wr && wb_req.adr == `ADDR_STATUS) begin
      // Timeout and powerdown bits are read-only from software
      next_core_status_flags[2:0] = wdata[2:0];
      next_core_status_flags[7:5] = wdata[7:5];
    end
  end

  // Events, mask, control and keep register with bus access
  always_comb begin
    next_events  = events;
    next_mask    = mask;
    next_control = control;
    next_keep_reg = keep_reg;
    next_ack_o   = cyc_i && stb_i && !ack_o;
    next_dat_o   = '0;
    if (wr && wb_req.adr == `ADDR_EVENTS)
      next_events = events & ~wdata;
    if (wr && wb_req.adr == `ADDR_MASK)
      next_mask = wdata;
    if (wr && wb_req.adr == `ADDR_CONTROL)
      next_control = wdata;
    if (wr && wb_req.adr == `ADDR_KEEP)
      next_keep_reg = wdata;
    // Set wins over a clear in the same cycle
    if (por_event)
      next_events[`EV_POR] = 1'b1;
    if (pin_low && !halted)
      next_events[`EV_PIN] = 1'b1;
    if (pin_low && halted)
      next_events[`EV_PIN_WAKE] = 1'b1;
    if (dog_event && !halted)
      next_events[`EV_DOG] = 1'b1;
    if (dog_event && halted)
      next_events[`EV_DOG_WAKE] = 1'b1;
    if (reset_latch && !any_cause && timer_done)
      next_events[`EV_RELEASE] = 1'b1;
    // Wake-up resets leave halt: full reset, no resume
    if (any_cause)
      next_control[`CTL_SLEEP] = 1'b0;
    if (rd) begin
      unique case (wb_req.adr)
        `ADDR_STATUS:  next_dat_o = {24'h000000, core_status_flags};
        `ADDR_EVENTS:  next_dat_o = {24'h000000, events};
        `ADDR_MASK:    next_dat_o = {24'h000000, mask};
        `ADDR_CONTROL: next_dat_o = {24'h000000, control};
        `ADDR_KEEP:    next_dat_o = {24'h000000, keep_reg};
        default:       next_dat_o = '0;
      endcase
    end
    next_irq = |(next_events & next_mask);
  end

  // Register stage; keep register has no reset term
  always_ff @(posedge mclk) begin
    keep_reg <= next_keep_reg;
    if (rst) begin
      reset_latch          <= 1'b1;
      device_startup_timer <= '0;
      por_seen             <= 1'b0;
      clk_div              <= 2'h0;
      instr_clock_out      <= 1'b0;
      core_status_flags    <= `STATUS_POR_VALUE;
      events               <= 8'h00;
      mask                 <= 8'h00;
      control              <= 8'h00;
      dat_o                <= 32'h00000000;
      ack_o                <= 1'b0;
      irq                  <= 1'b0;
      chip_reset           <= 1'b1;
    end else begin
      reset_latch          <= next_reset_latch;
      device_startup_timer <= next_device_startup_timer;
      por_seen             <= next_por_seen;
      clk_div              <= next_clk_div;
      instr_clock_out      <= next_instr_clock_out;
      core_status_flags    <= next_core_status_flags;
      events               <= next_events;
      mask                 <= next_mask;
      control              <= next_control;
      dat_o                <= next_dat_o;
      ack_o                <= next_ack_o;
      irq                  <= next_irq;
      chip_reset           <= next_reset_latch;
    end
  end

endmodule
`default_nettype wire

// [reset_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module reset_monitor
  import reset_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic               supply_rise,
  input wire logic               master_clear_pin,
  input wire logic               watchdog_timeout,
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire reset_pkg::wb_req_t wb_req,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  input wire logic               chip_reset,
  input wire logic               instr_clock_out,
  input wire logic               irq
);
  logic [7:0] quiet;
  logic [7:0] next_quiet;
  // Edges since the last cause; saturates so it never wraps
  always_comb begin
    next_quiet = quiet + {7'h0, quiet != 8'hff};
    if (rst | supply_rise | !master_clear_pin | watchdog_timeout) begin
      next_quiet = 8'h00;
    end
  end
  always_ff @(posedge mclk) begin
    quiet <= next_quiet;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_PIN_HOLD: assert property (!master_clear_pin |=> chip_reset)
    else $error("pin low left chip running");
  AST_POR_SET: assert property (supply_rise |=> chip_reset)
    else $error("power-on left chip running");
  AST_DOG_SET: assert property (watchdog_timeout |=> chip_reset)
    else $error("watchdog left chip running");
  AST_TIMER_HOLD: assert property (quiet < 18 |-> chip_reset)
    else $error("released before timeout");
  AST_RELEASE: assert property (quiet > 23 |-> !chip_reset)
    else $error("not released after timeout");
  AST_CLK_DIV: assert property ($rose(instr_clock_out) |=>
    instr_clock_out ##1 !instr_clock_out [*2] ##1 instr_clock_out)
    else $error("clock out not divide by four");
  AST_ACK_TIME: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  cover property ($fell(chip_reset));
  cover property (ack_o && irq);
  cover property (watchdog_timeout && !chip_reset);
endmodule
bind reset_source_and_startup_timer reset_monitor #(
  .STARTUP_CYCLES(STARTUP_CYCLES)
) u_mon (.mclk(mclk), .rst(rst), .supply_rise(supply_rise),
  .master_clear_pin(master_clear_pin), .watchdog_timeout(watchdog_timeout),
  .cyc_i(cyc_i), .stb_i(stb_i), .wb_req(wb_req), .dat_o(dat_o),
  .ack_o(ack_o), .chip_reset(chip_reset), .irq(irq),
  .instr_clock_out(instr_clock_out));
`default_nettype wire

// [reset_far_side.sv]
`timescale 1ns/10ps
`default_nettype none
module reset_far_side (
  input  wire logic hold_low,
  input  wire logic bite,
  input  wire logic mclk,
  output var logic  master_clear_pin,
  output var logic  watchdog_timeout
);
  // Pin starts low, as a supply ramp would leave it
  initial master_clear_pin = 1'b0;
  initial watchdog_timeout = 1'b0;
  always @(posedge mclk) begin
    master_clear_pin <= !hold_low;
    watchdog_timeout <= bite;
  end
endmodule
`default_nettype wire

// [tb_reset_source_and_startup_timer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "reset_params.svh"
module tb_reset_source_and_startup_timer;
  import reset_pkg::*;
  localparam int S = 20;
  logic        mclk = 0, rst = 1, supply_rise = 0, cyc = 0, stb = 0;
  logic        hold_low = 1, bite = 0;
  wb_req_t     wb_req = '0;
  logic        pin, dog, ack, chip_reset, clk_out, irq;
  logic [31:0] dat, rd;
  logic [31:0] seed = 32'ha4f8;
  logic [7:0]  exp_st, kp;
  int          error_cnt = 0, checked = 0, n;
  initial forever #12.5 mclk = ~mclk;
  reset_source_and_startup_timer #(.STARTUP_CYCLES(S))
    i_reset_source_and_startup_timer (.mclk(mclk), .rst(rst),
    .supply_rise(supply_rise), .master_clear_pin(pin), .watchdog_timeout(dog),
    .cyc_i(cyc), .stb_i(stb), .wb_req(wb_req), .dat_o(dat), .ack_o(ack),
    .chip_reset(chip_reset), .instr_clock_out(clk_out), .irq(irq));
  reset_far_side i_reset_far_side (.mclk(mclk), .hold_low(hold_low),
    .bite(bite), .master_clear_pin(pin), .watchdog_timeout(dog));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected timeout/powerdown pair per cause
  function automatic logic [1:0] flags(input int c, input logic [1:0] old);
    case (c)
      0: return old;
      1: return 2'b10;
      2: return 2'b01;
      default: return 2'b00;
    endcase
  endfunction
  // Classic cycle; no fixed latency assumed
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wb_req <= {a, w, 4'h1, 24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  // Skip the cause's own latency, then wait for release
  task automatic wait_rel();
    repeat (3) @(posedge mclk);
    n = 3;
    while (chip_reset !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) error_cnt++;
  endtask
  initial begin
    repeat (4000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    supply_rise <= 1'b1;
    @(posedge mclk) supply_rise <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(chip_reset, 1);
    hold_low <= 1'b0;
    wait_rel();
    chk(n >= S && n <= S + 4, 1);
    rchk(`ADDR_STATUS, 8'h18);
    rchk(`ADDR_EVENTS, 8'h23);
    chk(irq, 0);
    n = 0;
    repeat (8) begin
      @(posedge mclk);
      n = n + clk_out;
    end
    chk(n, 4);
    wb(`ADDR_MASK, 1'b1, 8'h20);
    exp_st = 8'h18;
    for (int i = 0; i < 4; i++) begin
      wb(`ADDR_STATUS, 1'b1, 8'he7);
      rd = xs();
      kp = rd[7:0];
      wb(`ADDR_KEEP, 1'b1, kp);
      wb(`ADDR_CONTROL, 1'b1, {7'h0, i[0]});
      repeat (xs() % 8) @(posedge mclk);
      if (i[1]) begin
        bite <= 1'b1;
        @(posedge mclk) bite <= 1'b0;
      end else begin
        hold_low <= 1'b1;
        repeat (3) @(posedge mclk);
        hold_low <= 1'b0;
      end
      wait_rel();
      exp_st = {3'h0, flags(i, exp_st[4:3]), 3'h7};
      rchk(`ADDR_STATUS, exp_st);
      wb(`ADDR_EVENTS, 1'b0, 8'h00);
      chk(rd[i + 1], 1);
      chk(irq, 1);
      rchk(`ADDR_CONTROL, 8'h00);
      rchk(`ADDR_KEEP, kp);
      wb(`ADDR_EVENTS, 1'b1, 8'hff);
      repeat (2) @(posedge mclk);
      chk(irq, 0);
    end
    rchk(8'h04, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
